//--- core/motion_mirror_pkg.sv
// Constants shared by the device mirror bank: register offsets, field
// positions, masks and reset values.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit address bus.
`default_nettype none

package motion_mirror_pkg;

  // --------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int STAT_W = 29;
  localparam int FN_NUM = 12;
  localparam int DREQ_NUM = 8;
  localparam int AXES = 32;
  localparam int CPUS = 4;
  localparam int IRQ_W = 3;

  // --------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_INTF = 8'h08;
  localparam logic [7:0] OFS_AXOFF = 8'h0C;
  localparam logic [7:0] OFS_AXDONE = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_DREQ_BASE = 8'h20;
  localparam logic [7:0] OFS_DREQ_LAST = 8'h3C;

  // --------------------------------------------------------------------
  // Status mirror fields (bit i mirrors status device number base + i)
  // --------------------------------------------------------------------
  localparam int BIT_FSTOP = 12;
  localparam logic [28:0] STAT_USABLE = 29'h1EFFFFFF;
  localparam logic [28:0] FSTOP_MASK = 29'h00001000;
  localparam logic [28:0] ERR_MASK = 29'h00F0E33F;
  localparam logic [28:0] XFER_MASK = 29'h1E000000;

  // --------------------------------------------------------------------
  // Command functions, in internal flag order
  // --------------------------------------------------------------------
  localparam int FN_HOST_READY = 0;
  localparam int FN_SPEED_SWITCH = 1;
  localparam int FN_SERVO_ON_ALL = 2;
  localparam int FN_VIRT_MODE = 3;
  localparam int FN_JOG_SIMUL = 4;
  localparam int FN_ERR_HIST_CLR = 8;
  localparam int FN_CLOCK_SET = 9;
  localparam int FN_CLOCK_READ = 10;
  localparam int FN_ERR_RESET = 11;
  localparam int CMD_COMMON_W = 9;
  localparam int CMD_SPECIAL_LSB = 16;

  // --------------------------------------------------------------------
  // Interrupt status bits and reset values
  // --------------------------------------------------------------------
  localparam int IRQ_ERR = 0;
  localparam int IRQ_XFER = 1;
  localparam int IRQ_START = 2;
  localparam logic [11:0] FN_RST = 12'h000;
  localparam logic [31:0] AXOFF_RST = 32'h00000000;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

endpackage

`default_nettype wire

//--- core/axis_flag_bank.sv
// Per-axis start complete flags with their clear command edge detection.
// Assumes all inputs come from logic on the same clock.
`default_nettype none

module axis_flag_bank (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [31:0] start_done,
  input wire logic [31:0] start_is_servo,
  input wire logic [31:0] pos_done,
  input wire logic [31:0] off_cmd,
  output logic [31:0] flag,
  output logic set_event
);

  logic [31:0] off_prev_r;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;

  // Only servo program starts complete a start; jog and handwheel do not.
  assign set_vec = start_done & start_is_servo; // RL12
  // A clear comes from a rising off command or a positioning completion.
  assign clr_vec = (off_cmd & ~off_prev_r) | pos_done; // RL13

  // ----------------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------------

  // Bit n belongs to axis n + 1; a set in the clearing cycle wins.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flag <= 32'h00000000;
      off_prev_r <= 32'h00000000;
      set_event <= 1'b0;
    end else begin
      flag <= (flag & ~clr_vec) | set_vec; // RL12 RL13 RL16
      off_prev_r <= off_cmd;
      set_event <= |(set_vec & ~flag);
    end
  end

endmodule

`default_nettype wire

//--- core/motion_cpu_device_mirror.sv
// Status and command device bank of the motion CPU, reached over APB.
// Assumes the cycle ticks, relay states and axis events come from logic
// on ref_clk, so none of them is synchronised here.
//
// Implementation choices: the register addresses and the APB register port.
`default_nettype none

// Functional notes
// RL1 - Status mirror bits equal their internal relays after each refresh.
// RL2 - Error flags are copied the same clock the error appears.
// RL3 - Four transfer complete flags, one per CPU, follow instruction completion.
// RL4 - Forced stop input flag is refreshed only on operation cycle ticks.
// RL5 - Command rising edge sets its internal flag, falling edge clears it.
// RL6 - Direct internal flag writes never change the command register.
// RL7 - Command edge beats a data register edge at the same fetch.
// RL8 - Software may also write internal flags directly.
// RL9 - Software clears the error history clear command; hardware never does.
// RL10 - Each command is sampled at its own fetch tick.
// RL11 - Clock set, clock read and error reset sample each main cycle.
// RL12 - Axis start complete sets on servo program start, not jog or handwheel.
// RL13 - Axis start complete clears on off command rise or positioning done.
// RL14 - Data register bit 0 rise turns flag on, fall turns it off.
// RL15 - Of two writes to one device, the later one stands.
// RL16 - Axis index equals axis number minus one, zero to thirty-one.
// RL17 - Unusable device positions read zero and ignore writes.
module motion_cpu_device_mirror (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [28:0] special_relay,
  input wire logic main_cycle_tick,
  input wire logic op_cycle_tick,
  input wire logic start_tick,
  input wire logic virt_mode_tick,
  input wire logic [31:0] axis_start_done,
  input wire logic [31:0] axis_start_is_servo,
  input wire logic [31:0] axis_pos_done,
  output logic [11:0] internal_flag,
  output logic [31:0] axis_start_complete_flag,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Packs the command register word into function order.
  function automatic logic [11:0] word_to_fn(input logic [31:0] w);
    word_to_fn = {w[18:16], w[8:0]};
  endfunction

  // Places the function vector into the command register layout.
  function automatic logic [31:0] fn_to_word(input logic [11:0] f);
    fn_to_word = {13'h0000, f[11:9], 7'h00, f[8:0]};
  endfunction

  // True when the address equals the given offset, in any bus phase.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [28:0] mirror_r;
  logic [28:0] mirror_nxt;
  logic [11:0] cmd_r;
  logic [11:0] cmd_seen_r;
  logic [11:0] fn_flag_r;
  logic [11:0] fetch;
  logic [11:0] cmd_chg;
  logic [7:0] dreq_r;
  logic [7:0] dreq_seen_r;
  logic [7:0] dreq_chg;
  logic [31:0] axoff_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_ev;
  logic [2:0] irq_clr;
  logic [31:0] prdata_nxt;
  logic [31:0] axdone;
  logic start_event;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic addr_ok;
  logic is_dreq;
  logic [2:0] dreq_idx;
  logic [28:0] err_prev_r;
  logic [28:0] xfer_prev_r;
  logic rd_irq_r;
  logic [11:0] intf_wdata;

  // ----------------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------------

  // Read data is built in the setup cycle so the access cycle never waits.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign is_dreq = (paddr >= motion_mirror_pkg::OFS_DREQ_BASE)
                   & (paddr <= motion_mirror_pkg::OFS_DREQ_LAST)
                   & (paddr[1:0] == 2'h0);
  assign dreq_idx = paddr[4:2];

  // Decodes which register, if any, the current address selects.
  always_comb begin
    addr_ok = 1'b1;
    prdata_nxt = 32'h00000000;
    if (hit(paddr, motion_mirror_pkg::OFS_STATUS)) begin
      prdata_nxt = {3'h0, mirror_r}; // RL1 RL17
    end else if (hit(paddr, motion_mirror_pkg::OFS_CMD)) begin
      prdata_nxt = fn_to_word(cmd_r); // RL6
    end else if (hit(paddr, motion_mirror_pkg::OFS_INTF)) begin
      prdata_nxt = fn_to_word(fn_flag_r);
    end else if (hit(paddr, motion_mirror_pkg::OFS_AXOFF)) begin
      prdata_nxt = axoff_r;
    end else if (hit(paddr, motion_mirror_pkg::OFS_AXDONE)) begin
      prdata_nxt = axdone;
    end else if (hit(paddr, motion_mirror_pkg::OFS_IRQ_ST)) begin
      prdata_nxt = {29'h00000000, irq_st_r};
    end else if (hit(paddr, motion_mirror_pkg::OFS_IRQ_MASK)) begin
      prdata_nxt = {29'h00000000, irq_mask_r};
    end else if (is_dreq) begin
      prdata_nxt = {31'h00000000, dreq_r[dreq_idx]};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read data and the error answer are registered during the setup cycle.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      rd_irq_r <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : prdata_nxt;
      pslverr <= ~addr_ok;
      rd_irq_r <= ~pwrite & hit(paddr, motion_mirror_pkg::OFS_IRQ_ST);
    end
  end

  // ----------------------------------------------------------------------
  // Status mirror
  // ----------------------------------------------------------------------

  // Event flags copy at once; forced stop waits for its operation tick.
  always_comb begin
    mirror_nxt = special_relay & ~motion_mirror_pkg::FSTOP_MASK; // RL2 RL3
    if (op_cycle_tick) begin
      mirror_nxt = mirror_nxt | (special_relay
                   & motion_mirror_pkg::FSTOP_MASK); // RL4
    end else begin
      mirror_nxt = mirror_nxt | (mirror_r
                   & motion_mirror_pkg::FSTOP_MASK);
    end
    mirror_nxt = mirror_nxt & motion_mirror_pkg::STAT_USABLE; // RL17
  end

  // Holds the mirrored status devices.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mirror_r <= 29'h00000000;
    end else begin
      mirror_r <= mirror_nxt; // RL1
    end
  end

  // ----------------------------------------------------------------------
  // Command register and data request registers
  // ----------------------------------------------------------------------

  // Software writes commands; unusable bits are dropped on the way in.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_r <= motion_mirror_pkg::FN_RST;
    end else if (wr & hit(paddr, motion_mirror_pkg::OFS_CMD)) begin
      cmd_r <= word_to_fn(pwdata); // RL9 RL15 RL17
    end
  end

  // Only bit 0 of each data request register is kept.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dreq_r <= 8'h00;
    end else if (wr & is_dreq) begin
      dreq_r[dreq_idx] <= pwdata[0]; // RL14 RL15
    end
  end

  // Per-axis complete signal off commands, bit n for axis n + 1.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      axoff_r <= motion_mirror_pkg::AXOFF_RST;
    end else if (wr & hit(paddr, motion_mirror_pkg::OFS_AXOFF)) begin
      axoff_r <= pwdata; // RL16
    end
  end

  // ----------------------------------------------------------------------
  // Fetch points
  // ----------------------------------------------------------------------

  // Each function looks at its command only on its own tick.
  always_comb begin
    fetch = {motion_mirror_pkg::FN_NUM{main_cycle_tick}}; // RL10 RL11
    fetch[motion_mirror_pkg::FN_SPEED_SWITCH] = start_tick; // RL10
    fetch[motion_mirror_pkg::FN_SERVO_ON_ALL] = op_cycle_tick; // RL10
    fetch[motion_mirror_pkg::FN_VIRT_MODE] = virt_mode_tick;
  end

  assign cmd_chg = cmd_r ^ cmd_seen_r;
  assign dreq_chg = dreq_r ^ dreq_seen_r;

  // Remembers the command and request levels seen at the last fetch.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_seen_r <= motion_mirror_pkg::FN_RST;
      dreq_seen_r <= 8'h00;
    end else begin
      for (int i = 0; i < motion_mirror_pkg::FN_NUM; i++) begin
        if (fetch[i]) begin
          cmd_seen_r[i] <= cmd_r[i];
        end
      end
      for (int i = 0; i < motion_mirror_pkg::DREQ_NUM; i++) begin
        if (fetch[i]) begin
          dreq_seen_r[i] <= dreq_r[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Internal request flags
  // ----------------------------------------------------------------------

  // A command edge wins over a data request edge at the same fetch, and
  // both win over a direct write landing on the same clock.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fn_flag_r <= motion_mirror_pkg::FN_RST;
    end else begin
      for (int i = 0; i < motion_mirror_pkg::FN_NUM; i++) begin
        if (fetch[i] & cmd_chg[i]) begin
          fn_flag_r[i] <= cmd_r[i]; // RL5 RL7
        end else if (i < motion_mirror_pkg::DREQ_NUM && fetch[i]
                     && dreq_chg[i[2:0]]) begin
          fn_flag_r[i] <= dreq_r[i[2:0]]; // RL14
        end else if (wr & hit(paddr, motion_mirror_pkg::OFS_INTF)) begin
          fn_flag_r[i] <= intf_wdata[i]; // RL6 RL8 RL15
        end
      end
    end
  end

  assign internal_flag = fn_flag_r;
  assign intf_wdata = word_to_fn(pwdata);

  // ----------------------------------------------------------------------
  // Per-axis start complete flags
  // ----------------------------------------------------------------------

  // The bank keeps one flag per axis and reports new sets.
  axis_flag_bank u_axis_bank (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start_done(axis_start_done),
    .start_is_servo(axis_start_is_servo),
    .pos_done(axis_pos_done),
    .off_cmd(axoff_r),
    .flag(axdone),
    .set_event(start_event)
  );

  assign axis_start_complete_flag = axdone;

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------

  // Edge history for error and transfer complete status bits.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      err_prev_r <= 29'h00000000;
      xfer_prev_r <= 29'h00000000;
    end else begin
      err_prev_r <= mirror_r & motion_mirror_pkg::ERR_MASK;
      xfer_prev_r <= mirror_r & motion_mirror_pkg::XFER_MASK;
    end
  end

  // Events: a new error, a finished transfer, a new axis start complete.
  always_comb begin
    irq_ev = 3'h0;
    irq_ev[motion_mirror_pkg::IRQ_ERR] =
      |(mirror_r & motion_mirror_pkg::ERR_MASK & ~err_prev_r);
    irq_ev[motion_mirror_pkg::IRQ_XFER] =
      |(mirror_r & motion_mirror_pkg::XFER_MASK & ~xfer_prev_r);
    irq_ev[motion_mirror_pkg::IRQ_START] = start_event;
  end

  // A status read clears only the bits it returned.
  assign irq_clr = (rd & rd_irq_r) ? prdata[2:0] : 3'h0;

  // Sticky status; a new event in the clearing cycle stays set.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_st_r <= 3'h0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
    end
  end

  // Mask register, same layout as the status register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_mask_r <= motion_mirror_pkg::IRQ_MASK_RST;
    end else if (wr & hit(paddr, motion_mirror_pkg::OFS_IRQ_MASK)) begin
      irq_mask_r <= pwdata[2:0];
    end
  end

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_st_r & ~irq_clr | irq_ev) & irq_mask_r);
    end
  end

endmodule

`default_nettype wire

//--- dv/mirror_sva.sv
// Concurrent checks on the port pins of the device mirror bank.
// Assumes one clock, ref_clk, and a synchronous active-high sys_rst.
`default_nettype none

module mirror_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [28:0] special_relay,
  input wire logic main_cycle_tick,
  input wire logic op_cycle_tick,
  input wire logic start_tick,
  input wire logic virt_mode_tick,
  input wire logic [31:0] axis_start_done,
  input wire logic [31:0] axis_start_is_servo,
  input wire logic [31:0] axis_pos_done,
  input wire logic [11:0] internal_flag,
  input wire logic [31:0] axis_start_complete_flag,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------------
  // Helper terms
  // ------------------------------------------------------------------
  // Address decode, servo start events and direct flag writes.
  logic mapped;
  logic flag_wr;
  logic [31:0] srv;
  assign mapped = paddr <= 8'h18 || (paddr >= 8'h20 && paddr <= 8'h3C);
  assign flag_wr = psel && penable && pwrite && paddr == 8'h08;
  assign srv = axis_start_done & axis_start_is_servo;

  // ------------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------------
  a_pready_high: assert property (pready)
    else $error("pready dropped");
  a_unmapped_err: assert property (
    psel && !penable && paddr[1:0] == 2'h0 && !mapped
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok: assert property (
    psel && !penable && paddr[1:0] == 2'h0 && mapped |=> !pslverr)
    else $error("mapped address refused");

  // ------------------------------------------------------------------
  // Axis start complete flags
  // ------------------------------------------------------------------
  a_axis_servo_set: assert property (
    srv != 32'h0 |=> (axis_start_complete_flag & $past(srv)) == $past(srv))
    else $error("servo start did not set flag");
  a_axis_no_jog: assert property (
    (axis_start_complete_flag & ~$past(axis_start_complete_flag)
     & ~$past(srv)) == 32'h0) else $error("flag set without servo start");
  a_axis_pos_clear: assert property (
    (axis_pos_done & ~srv) != 32'h0 |=>
    (axis_start_complete_flag & $past(axis_pos_done & ~srv)) == 32'h0)
    else $error("positioning done did not clear flag");

  // ------------------------------------------------------------------
  // Fetch points and interrupt
  // ------------------------------------------------------------------
  a_main_fetch: assert property (
    !$past(sys_rst) && ((internal_flag ^ $past(internal_flag)) & 12'hFF1)
    != 12'h0 |-> $past(main_cycle_tick) || $past(main_cycle_tick, 2)
    || $past(flag_wr) || $past(flag_wr, 2))
    else $error("main cycle flag moved off its fetch");
  a_op_fetch: assert property (
    !$past(sys_rst) && internal_flag[2] != $past(internal_flag[2])
    |-> $past(op_cycle_tick) || $past(op_cycle_tick, 2)
    || $past(flag_wr) || $past(flag_wr, 2))
    else $error("servo on flag moved off its fetch");
  a_irq_bus_clear: assert property (
    !$past(sys_rst) && $fell(irq)
    |-> $past(psel && penable) || $past(psel && penable, 2))
    else $error("irq fell without a bus access");
endmodule

bind motion_cpu_device_mirror mirror_sva i_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .special_relay(special_relay),
  .main_cycle_tick(main_cycle_tick), .op_cycle_tick(op_cycle_tick),
  .start_tick(start_tick), .virt_mode_tick(virt_mode_tick),
  .axis_start_done(axis_start_done),
  .axis_start_is_servo(axis_start_is_servo),
  .axis_pos_done(axis_pos_done), .internal_flag(internal_flag),
  .axis_start_complete_flag(axis_start_complete_flag), .irq(irq));

`default_nettype wire

//--- dv/plc_host_model.sv
// Host program model: an APB master that writes commands, reads status.
// Assumes the slave shares ref_clk; a stalled answer ends after 50 waits.
`default_nettype none

module plc_host_model (
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; write data is inverted once released so stale data
  // cannot pass for a held value.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err, output bit ok);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    ok = (pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask
endmodule

`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the device mirror bank.
// Assumes the host model drives APB; the bench drives ticks and events.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [1:0] tk;
    logic [31:0] cmd;
    logic [11:0] flag;
  } row_t;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] tk = 4'h0;
  logic [28:0] relay = 29'h0;
  logic [31:0] done = 32'h0;
  logic [31:0] servo = 32'h0;
  logic [31:0] pos = 32'h0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, axflag;
  logic [11:0] flag;
  int err_total = 0;
  int n_tests = 0;
  // Tick per function: 0 main, 1 start, 2 operation, 3 virtual mode.
  row_t rows [12] = '{
    '{2'h0, 32'h00000001, 12'h001}, '{2'h1, 32'h00000002, 12'h002},
    '{2'h2, 32'h00000004, 12'h004}, '{2'h3, 32'h00000008, 12'h008},
    '{2'h0, 32'h00000010, 12'h010}, '{2'h0, 32'h00000020, 12'h020},
    '{2'h0, 32'h00000040, 12'h040}, '{2'h0, 32'h00000080, 12'h080},
    '{2'h0, 32'h00000100, 12'h100}, '{2'h0, 32'h00010000, 12'h200},
    '{2'h0, 32'h00020000, 12'h400}, '{2'h0, 32'h00040000, 12'h800}};

  // Clock of 40 ns period.
  always #20 ref_clk = ~ref_clk;

  motion_cpu_device_mirror i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .special_relay(relay),
    .main_cycle_tick(tk[0]), .start_tick(tk[1]), .op_cycle_tick(tk[2]),
    .virt_mode_tick(tk[3]), .axis_start_done(done),
    .axis_start_is_servo(servo), .axis_pos_done(pos),
    .internal_flag(flag), .axis_start_complete_flag(axflag), .irq(irq));

  plc_host_model i_host (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic xe);
    logic [31:0] r;
    logic e;
    bit ok;
    i_host.xfer(w, a, d, r, e, ok);
    if (!ok) begin
      err_total++;
      tally_and_finish();
    end
    if (!w) chk($sformatf("rd %h", a), x, r);
    chk($sformatf("pslverr %h", a), {31'h0, xe}, {31'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic pulse(input int k);
    @(posedge ref_clk);
    tk[k] <= 1'b1;
    @(posedge ref_clk);
    tk[k] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic ev(input logic [31:0] d, input logic [31:0] p);
    @(posedge ref_clk);
    done <= d;
    pos <= p;
    @(posedge ref_clk);
    done <= 32'h0;
    pos <= 32'h0;
    repeat (2) @(posedge ref_clk);
  endtask

  // Hang guard.
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("flags", 32'h0, {20'h0, flag});
    chk("irq", 32'h0, {31'h0, irq});
    acc(1'b0, motion_mirror_pkg::OFS_CMD, 32'h0, 32'h0, 1'b0);
    acc(1'b0, motion_mirror_pkg::OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0);
    $display("test reset done");
    for (int f = 0; f < 12; f++) begin
      wr(motion_mirror_pkg::OFS_CMD, rows[f].cmd);
      for (int k = 0; k < 4; k++)
        if (k != int'(rows[f].tk)) pulse(k);
      chk("not fetched", 32'h0, {20'h0, flag});
      pulse(int'(rows[f].tk));
      chk("fetch set", {20'h0, rows[f].flag}, {20'h0, flag});
      wr(motion_mirror_pkg::OFS_CMD, 32'h0);
      pulse(int'(rows[f].tk));
      chk("fetch clear", 32'h0, {20'h0, flag});
    end
    $display("test command table done");
    relay <= 29'h1FFFFFFF;
    repeat (3) @(posedge ref_clk);
    acc(1'b0, 8'h00, 32'h0, {3'h0, motion_mirror_pkg::STAT_USABLE
        & ~motion_mirror_pkg::FSTOP_MASK}, 1'b0);
    pulse(2);
    acc(1'b0, 8'h00, 32'h0, {3'h0, motion_mirror_pkg::STAT_USABLE},
        1'b0);
    servo <= 32'h80000000;
    ev(32'h80000001, 32'h0);
    chk("axis set", 32'h80000000, axflag);
    acc(1'b0, motion_mirror_pkg::OFS_AXDONE, 32'h0, 32'h80000000, 1'b0);
    wr(motion_mirror_pkg::OFS_IRQ_MASK, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(motion_mirror_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq mask", 32'h0, {31'h0, irq});
    acc(1'b0, motion_mirror_pkg::OFS_IRQ_ST, 32'h0, 32'h7, 1'b0);
    acc(1'b0, motion_mirror_pkg::OFS_IRQ_ST, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    acc(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 8'h40, 32'hFFFFFFFF, 32'h0, 1'b1);
    $display("test status and irq done");
    wr(motion_mirror_pkg::OFS_AXOFF, 32'h80000000);
    repeat (3) @(posedge ref_clk);
    chk("axis off", 32'h0, axflag);
    ev(32'h80000000, 32'h0);
    ev(32'h0, 32'h80000000);
    chk("axis pos done", 32'h0, axflag);
    $display("test axis done");
    wr(motion_mirror_pkg::OFS_INTF, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("direct", 32'h1, {20'h0, flag});
    acc(1'b0, motion_mirror_pkg::OFS_CMD, 32'h0, 32'h0, 1'b0);
    wr(motion_mirror_pkg::OFS_CMD, 32'h1);
    wr(motion_mirror_pkg::OFS_CMD, 32'h0);
    pulse(0);
    chk("later write", 32'h1, {20'h0, flag});
    wr(motion_mirror_pkg::OFS_INTF, 32'h0);
    wr(motion_mirror_pkg::OFS_DREQ_BASE, 32'hFFFFFFFE);
    pulse(0);
    chk("upper bits", 32'h0, {20'h0, flag});
    wr(motion_mirror_pkg::OFS_DREQ_BASE, 32'h1);
    pulse(0);
    chk("request on", 32'h1, {20'h0, flag});
    wr(motion_mirror_pkg::OFS_CMD, 32'h1);
    wr(motion_mirror_pkg::OFS_DREQ_BASE, 32'h0);
    pulse(0);
    chk("command wins", 32'h1, {20'h0, flag});
    $display("test direct and request done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
